// *** hw/sgrc_pkg.sv ***
/*
 * Package for the sleep, clock-gate and reset controller: register map,
 * field positions, sleep mode codes, timing counts and bus carriers.
 * Assumes a classic Wishbone master with 32-bit data, one word per register.
 */
package sgrc_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0]  IDX_SLEEP_MODE_CONTROL = 8'h33;
	localparam logic [7:0]  IDX_CORE_CONTROL       = 8'h35;
	localparam logic [7:0]  IDX_PERIPH_CLOCK_GATE  = 8'h64;
	localparam logic [7:0]  IDX_RESET_CONFIG       = 8'h70;
	localparam logic [7:0]  IDX_RESET_STATUS       = 8'h71;
	localparam logic [7:0]  IDX_POWER_STATUS       = 8'h72;
	localparam logic [1:0]  BYTE_SHIFT             = 2'h2;

	localparam logic [7:0]  SLEEP_MODE_CONTROL_RST = 8'h00;
	localparam logic [7:0]  CORE_CONTROL_RST       = 8'h00;
	localparam logic [7:0]  PERIPH_CLOCK_GATE_RST  = 8'h00;
	localparam logic [15:0] RESET_CONFIG_RST       = 16'h0040;

	// field positions
	localparam int SLEEP_ARM_BIT     = 0;
	localparam int SLEEP_MODE_LSB    = 1;
	localparam int CORE_JTD_BIT      = 7;
	localparam int BOD_OFF_BIT       = 6;
	localparam int BOD_UNLOCK_BIT    = 5;
	localparam int CORE_PUD_BIT      = 4;
	localparam int CORE_IVSEL_BIT    = 1;
	localparam int CORE_IVCE_BIT     = 0;
	localparam logic [7:0] CORE_RW_MASK = 8'h93;

	localparam int GATE_TWO_WIRE = 7;
	localparam int GATE_TIMER2   = 6;
	localparam int GATE_TIMER0   = 5;
	localparam int GATE_SERIAL1  = 4;
	localparam int GATE_TIMER1   = 3;
	localparam int GATE_SPI      = 2;
	localparam int GATE_SERIAL0  = 1;
	localparam int GATE_ADC      = 0;

	typedef enum logic [2:0] {
		SGRC_MODE_IDLE      = 3'h0,
		SGRC_MODE_ADC_NR    = 3'h1,
		SGRC_MODE_PWR_DOWN  = 3'h2,
		SGRC_MODE_PWR_SAVE  = 3'h3,
		SGRC_MODE_RSVD4     = 3'h4,
		SGRC_MODE_RSVD5     = 3'h5,
		SGRC_MODE_STANDBY   = 3'h6,
		SGRC_MODE_EXT_STBY  = 3'h7
	} sgrc_mode_t;

	// timing
	localparam int CLK_MHZ             = 200;
	localparam int BOD_UNLOCK_CYCLES   = 4;
	localparam int BOD_ACTIVE_DELAY    = 3;
	localparam int BOD_AUTO_CLEAR      = 3;
	localparam logic [2:0] BOD_UNLOCK_CNT = 3'(BOD_UNLOCK_CYCLES);
	localparam logic [2:0] BOD_ACT_CNT    = 3'(BOD_ACTIVE_DELAY);
	localparam logic [2:0] BOD_CLR_CNT    = 3'(BOD_AUTO_CLEAR);
	localparam int RESET_TIMEOUT_US    = 65;
	localparam int RESET_TIMEOUT_CYC   = RESET_TIMEOUT_US * CLK_MHZ;
	localparam int TOUT_W              = 20;
	localparam logic [TOUT_W-1:0] TOUT_ZERO = 20'h0_0000;
	localparam logic [TOUT_W-1:0] TOUT_ONE  = 20'h0_0001;

	typedef enum logic [3:0] {
		SGRC_RST_HOLD    = 4'b0001,
		SGRC_RST_STRETCH = 4'b0010,
		SGRC_RST_RUN     = 4'b0100,
		SGRC_RST_SPARE   = 4'b1000
	} sgrc_rst_state_t;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [3:0]  sel;
		logic [9:0]  adr;
		logic [31:0] dat;
	} sgrc_wb_req_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} sgrc_wb_rsp_t;

	typedef struct packed {
		logic por;
		logic ext_pin_low;
		logic wdt_expire;
		logic wdt_enabled;
		logic bod_below;
		logic bod_enabled;
		logic jtag_reset_reg;
	} sgrc_rst_src_t;
endpackage : sgrc_pkg

// *** hw/sgrc_top.sv ***
/*
 * Sleep mode control, brown-out-off unlock sequence, peripheral clock gates
 * and reset source combiner with a stretch counter, behind a Wishbone slave.
 * Assumes reset source flags are synchronous to MCLK except the power-on and
 * pin reset, which act asynchronously through the port reset output.
 */
// The implementer's own choice: the Wishbone slave port.
// Summary of operation
// - sleep mode field: idle, ADC noise, power-down, power-save, standby, ext standby.
// - sleep instruction enters a mode only while sleep arm bit is set.
// - brown-out-off needs unlock write, then set write within four cycles.
// - brown-out-off active three cycles after set; sleep then disables detector.
// - brown-out-off bit clears itself three cycles after set.
// - each clock-gate bit stops one peripheral clock when one.
// - timer 2 gate acts only in synchronous mode.
// - ungated timers resume from their frozen state.
// - ADC disabled before gating; comparator cannot use ADC mux while gated.
// - all registers take initial values in reset (reset config and status only on RST_N, not internal reset); fetch starts at reset vector.
// - ports reset immediately on any source without a clock; the watchdog pulse is registered and reaches them one MCLK edge later.
// - delay counter stretches internal reset after all sources go inactive.
// - internal reset from power-on, pin, watchdog, brown-out and JTAG.
// - watchdog reset when period expires while enabled.
// - brown-out reset only while detector enabled and supply low.
// - JTAG reset holds while its reset register holds one.
// - power-on reset reasserts internal reset immediately.
// - long low pin pulse resets without clock; short ones not guaranteed.
// - pin release starts time-out before internal reset lifts.
// - gated peripheral frozen, its registers neither readable nor writable.
// - watchdog gives a one-cycle pulse; counter starts on its fall.
module sgrc_top
	import sgrc_pkg::*;
#(
	parameter logic [TOUT_W-1:0] TIMEOUT_CYCLES = TOUT_W'(RESET_TIMEOUT_CYC)
) (
	input  wire logic                 MCLK,            // system clock
	input  wire logic                 RST_N,           // async reset, active low
	input  wire sgrc_pkg::sgrc_wb_req_t WB_REQ,        // wishbone request
	output      sgrc_pkg::sgrc_wb_rsp_t WB_RSP,        // wishbone answer
	input  wire logic                 SLEEP_INSTR,     // sleep instruction pulse
	input  wire logic                 TIMER2_ASYNC_SELECT, // timer 2 async clock
	input  wire logic                 ADC_ENABLED,     // ADC enable state
	input  wire sgrc_pkg::sgrc_rst_src_t RST_SRC,      // reset source flags
	input  wire logic [5:0]           PERIPH_SEL,      // peripheral register select
	output      logic                 SLEEP_ENTER,     // sleep entered pulse
	output      logic [2:0]           SLEEP_MODE,      // mode taken at entry
	output      logic                 BOD_SLEEP_OFF,   // detector off for this sleep
	output      logic [7:0]           GATE_CLK,        // per-peripheral clock stop
	output      logic [7:0]           PERIPH_ACCESS_OK,// peripheral register access
	output      logic                 ADC_GATE_ERR,    // ADC gated while enabled
	output      logic                 COMPARATOR_MUX_BLOCK, // comparator mux blocked
	output      logic                 PORT_RESET,      // immediate port reset
	output      logic                 INTERNAL_RESET,  // stretched core reset
	output      logic                 FETCH_AT_VECTOR  // fetch from reset vector pulse
);
	import sgrc_pkg::*;

	logic [7:0]        sleep_ctrl;
	logic [7:0]        core_ctrl;
	logic [7:0]        gate;
	logic [15:0]       rst_cfg;
	logic [4:0]        rst_flags;
	logic              ack;
	logic [31:0]       rdata;
	logic [2:0]        unlock_cnt;
	logic [2:0]        bod_age;
	logic              bod_set;
	logic              bod_active;
	logic [TOUT_W-1:0] tout_cnt;
	logic              wdt_pulse_d;
	logic              internal_rst;
	logic              run_d;
	sgrc_rst_state_t   rst_state;
	sgrc_rst_state_t   next_rst_state;

	wire logic       req     = WB_REQ.cyc & WB_REQ.stb & ~ack;
	wire logic [7:0] idx     = WB_REQ.adr[9:2];
	wire logic       wr      = req & WB_REQ.we & WB_REQ.sel[0];
	wire logic [7:0] wbyte   = WB_REQ.dat[7:0];
	wire logic       wr_core = wr & (idx == IDX_CORE_CONTROL);
	wire logic       sleep_arm = sleep_ctrl[SLEEP_ARM_BIT];
	wire logic [2:0] mode_sel  = sleep_ctrl[SLEEP_MODE_LSB +: 3];

	// async sources; clockless port reset
	wire logic pin_or_por = RST_SRC.por | RST_SRC.ext_pin_low;
	wire logic wdt_rst  = RST_SRC.wdt_expire & RST_SRC.wdt_enabled;
	wire logic bod_rst  = RST_SRC.bod_below & RST_SRC.bod_enabled;
	wire logic jtag_rst = RST_SRC.jtag_reset_reg;
	wire logic any_src  = pin_or_por | wdt_pulse_d | bod_rst | jtag_rst;

	assign PORT_RESET = ~RST_N | any_src;

	// wishbone slave: registered answer one cycle after the strobe, ack dropped next cycle
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			ack <= 1'b0;
		end else begin
			ack <= req;
		end
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			rdata <= 32'h0000_0000;
		end else if (req) begin
			case (idx)
				IDX_SLEEP_MODE_CONTROL: rdata <= {24'h00_0000, sleep_ctrl};
				IDX_CORE_CONTROL:       rdata <= {24'h00_0000, core_ctrl};
				IDX_PERIPH_CLOCK_GATE:  rdata <= {24'h00_0000, gate};
				IDX_RESET_CONFIG:       rdata <= {16'h0000, rst_cfg};
				IDX_RESET_STATUS:       rdata <= {27'h000_0000, rst_flags};
				IDX_POWER_STATUS:       rdata <= {29'h0000_0000, run_d, bod_active,
					ADC_GATE_ERR};
				default:                rdata <= 32'h0000_0000;
			endcase
		end
	end

	assign WB_RSP = '{ack: ack, dat: rdata};

	// sleep mode control, cleared by any internal reset
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			sleep_ctrl <= SLEEP_MODE_CONTROL_RST;
		end else if (internal_rst) begin
			sleep_ctrl <= SLEEP_MODE_CONTROL_RST;
		end else if (wr && idx == IDX_SLEEP_MODE_CONTROL) begin
			sleep_ctrl <= {4'h0, wbyte[3:0]};
		end
	end

	// brown-out-off unlock window: opens on a write with both bits one
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			unlock_cnt <= 3'h0;
		end else if (internal_rst) begin
			unlock_cnt <= 3'h0;
		end else if (wr_core && wbyte[BOD_OFF_BIT] && wbyte[BOD_UNLOCK_BIT]) begin
			unlock_cnt <= BOD_UNLOCK_CNT;
		end else if (unlock_cnt != 3'h0) begin
			unlock_cnt <= unlock_cnt - 3'h1;
		end
	end

	wire logic bod_commit = wr_core && unlock_cnt != 3'h0 && wbyte[BOD_OFF_BIT]
		&& !wbyte[BOD_UNLOCK_BIT];

	// bod_age counts from set: active at age two, self-clear after three
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			bod_set <= 1'b0;
			bod_age <= 3'h0;
		end else if (internal_rst) begin
			bod_set <= 1'b0;
			bod_age <= 3'h0;
		end else if (bod_commit) begin
			bod_set <= 1'b1;
			bod_age <= 3'h0;
		end else if (bod_set) begin
			bod_age <= bod_age + 3'h1;
			if (bod_age == BOD_CLR_CNT - 3'h1) begin
				bod_set <= 1'b0;
			end
		end
	end

	// a self-clearing bit cannot both wait three and live three: it is
	// active on the final age step, which is when the sleep must come
	assign bod_active = bod_set && bod_age >= BOD_ACT_CNT - 3'h1;

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			core_ctrl <= CORE_CONTROL_RST;
		end else if (internal_rst) begin
			core_ctrl <= CORE_CONTROL_RST;
		end else begin
			if (wr_core) begin
				core_ctrl <= (wbyte & CORE_RW_MASK);
			end
			core_ctrl[BOD_OFF_BIT]    <= bod_set | bod_commit;
			core_ctrl[BOD_UNLOCK_BIT] <= (unlock_cnt != 3'h0) | (wr_core
				&& wbyte[BOD_OFF_BIT] && wbyte[BOD_UNLOCK_BIT]);
		end
	end

	// sleep entry
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			SLEEP_ENTER   <= 1'b0;
			SLEEP_MODE    <= SGRC_MODE_IDLE;
			BOD_SLEEP_OFF <= 1'b0;
		end else begin
			SLEEP_ENTER <= SLEEP_INSTR && sleep_arm && !internal_rst;
			if (SLEEP_INSTR && sleep_arm && !internal_rst) begin
				SLEEP_MODE    <= mode_sel;
				BOD_SLEEP_OFF <= bod_active;
			end
		end
	end

	// clock gates, cleared on internal reset like sleep and core control; reset config and status are not
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			gate <= PERIPH_CLOCK_GATE_RST;
		end else if (internal_rst) begin
			gate <= PERIPH_CLOCK_GATE_RST;
		end else if (wr && idx == IDX_PERIPH_CLOCK_GATE) begin
			gate <= wbyte;
		end
	end

	// gated clocks freeze state rather than reset it, so ungating resumes
	always_comb begin
		GATE_CLK = gate;
		GATE_CLK[GATE_TIMER2] = gate[GATE_TIMER2] & ~TIMER2_ASYNC_SELECT;
	end

	assign PERIPH_ACCESS_OK = ~GATE_CLK;
	assign COMPARATOR_MUX_BLOCK = gate[GATE_ADC];
	assign ADC_GATE_ERR = gate[GATE_ADC] & ADC_ENABLED;

	// reset combiner and stretch counter
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			wdt_pulse_d <= 1'b0;
		end else begin
			wdt_pulse_d <= wdt_rst & ~wdt_pulse_d;
		end
	end

	always_comb begin
		next_rst_state = rst_state;
		case (rst_state)
			SGRC_RST_HOLD:    if (!any_src) next_rst_state = SGRC_RST_STRETCH;
			SGRC_RST_STRETCH: begin
				if (any_src) begin
					next_rst_state = SGRC_RST_HOLD;
				end else if (tout_cnt >= TIMEOUT_CYCLES - TOUT_ONE) begin
					next_rst_state = SGRC_RST_RUN;
				end
			end
			SGRC_RST_RUN:     if (any_src) next_rst_state = SGRC_RST_HOLD;
			default:          next_rst_state = SGRC_RST_HOLD;
		endcase
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			rst_state <= SGRC_RST_HOLD;
		end else begin
			rst_state <= next_rst_state;
		end
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			tout_cnt <= TOUT_ZERO;
		end else if (rst_state != SGRC_RST_STRETCH || any_src) begin
			tout_cnt <= TOUT_ZERO;
		end else begin
			tout_cnt <= tout_cnt + TOUT_ONE;
		end
	end

	// power-on and pin bypass the counter, acting combinationally
	assign internal_rst   = (rst_state != SGRC_RST_RUN) | any_src;
	assign INTERNAL_RESET = internal_rst | ~RST_N;

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			run_d <= 1'b0;
		end else begin
			run_d <= ~internal_rst;
		end
	end

	assign FETCH_AT_VECTOR = ~internal_rst & ~run_d;

	// sticky cause flags: sets win over software clear-by-one
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			rst_flags <= 5'h01;
			rst_cfg   <= RESET_CONFIG_RST;
		end else begin
			if (wr && idx == IDX_RESET_STATUS) begin
				rst_flags <= (rst_flags & ~wbyte[4:0]) | {jtag_rst, wdt_pulse_d,
					bod_rst, RST_SRC.ext_pin_low, RST_SRC.por};
			end else begin
				rst_flags <= rst_flags | {jtag_rst, wdt_pulse_d, bod_rst,
					RST_SRC.ext_pin_low, RST_SRC.por};
			end
			if (wr && idx == IDX_RESET_CONFIG) begin
				rst_cfg <= WB_REQ.dat[15:0];
			end
		end
	end
endmodule : sgrc_top

// *** testbench/sgrc_core_model.sv ***
/*
 * Core model: issues classic Wishbone cycles and sleep instruction pulses.
 * Assumes the slave acks every taken request; the bench bounds all waits.
 */
module sgrc_core_model
	import sgrc_pkg::*;
(
	input  wire sgrc_pkg::sgrc_wb_rsp_t wb_rsp,      // slave answer
	input  wire logic                   mclk,        // system clock
	output      sgrc_pkg::sgrc_wb_req_t wb_req,      // request to slave
	output      logic                   sleep_instr  // sleep instruction
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		wb_req = '0;
		sleep_instr = 1'b0;
	end
	// request held unchanged until ack is sampled at an edge
	task automatic bus(input logic we, input logic [7:0] idx, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge mclk);
		wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'h1, adr: {idx, 2'h0}, dat: wd};
		do @(posedge mclk); while (wb_rsp.ack !== 1'b1);
		rd = wb_rsp.dat;
		wb_req <= '0;
	endtask : bus
	task automatic pulse_sleep();
		@(posedge mclk);
		sleep_instr <= 1'b1;
		@(posedge mclk);
		sleep_instr <= 1'b0;
	endtask : pulse_sleep
endmodule : sgrc_core_model

// *** testbench/sgrc_top_asserts.sv ***
/*
 * Checker for the sleep, gate and reset controller top ports.
 * Assumes the single clock and async low reset of that top; bound below.
 */
module sgrc_top_asserts
	import sgrc_pkg::*;
#(
	parameter logic [TOUT_W-1:0] TIMEOUT_CYCLES = TOUT_W'(RESET_TIMEOUT_CYC)
) (
	input wire logic                    MCLK,                 // clock
	input wire logic                    RST_N,                // reset
	input wire sgrc_pkg::sgrc_rst_src_t RST_SRC,              // sources
	input wire logic                    SLEEP_INSTR,          // sleep
	input wire logic                    TIMER2_ASYNC_SELECT,  // t2 async
	input wire logic                    ADC_ENABLED,          // adc on
	input wire logic                    SLEEP_ENTER,          // entered
	input wire logic                    BOD_SLEEP_OFF,        // bod off
	input wire logic [7:0]              GATE_CLK,             // gates
	input wire logic [7:0]              PERIPH_ACCESS_OK,     // access
	input wire logic                    ADC_GATE_ERR,         // adc err
	input wire logic                    COMPARATOR_MUX_BLOCK, // mux block
	input wire logic                    PORT_RESET,           // port rst
	input wire logic                    INTERNAL_RESET,       // core rst
	input wire logic                    FETCH_AT_VECTOR       // fetch
);
	timeunit 1ns;
	timeprecision 1ps;
	logic              src;
	logic [TOUT_W-1:0] quiet;
	assign src = RST_SRC.por | RST_SRC.ext_pin_low | RST_SRC.jtag_reset_reg
		| (RST_SRC.bod_below & RST_SRC.bod_enabled) | (RST_SRC.wdt_expire & RST_SRC.wdt_enabled);
	// quiet cycles since last source; saturates so it never wraps
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N)
			quiet <= TOUT_ZERO;
		else if (src)
			quiet <= TOUT_ZERO;
		else if (quiet < TIMEOUT_CYCLES + 20'h0_0008)
			quiet <= quiet + TOUT_ONE;
	end
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RST_N);
	sequence s_fetch_end;
		$past(INTERNAL_RESET) && !INTERNAL_RESET ##1 !FETCH_AT_VECTOR;
	endsequence
	property p_arm;
		SLEEP_ENTER |-> $past(SLEEP_INSTR) && !$past(INTERNAL_RESET);
	endproperty
	property p_bod_off;
		$rose(BOD_SLEEP_OFF) |-> SLEEP_ENTER;
	endproperty
	property p_t2;
		TIMER2_ASYNC_SELECT |-> !GATE_CLK[GATE_TIMER2];
	endproperty
	property p_adc;
		ADC_GATE_ERR == (COMPARATOR_MUX_BLOCK && ADC_ENABLED);
	endproperty
	property p_access;
		PERIPH_ACCESS_OK == ~GATE_CLK;
	endproperty
	property p_port;
		(RST_SRC.por || RST_SRC.ext_pin_low || RST_SRC.jtag_reset_reg) |-> PORT_RESET;
	endproperty
	property p_por;
		RST_SRC.por |-> INTERNAL_RESET;
	endproperty
	property p_jtag;
		RST_SRC.jtag_reset_reg |-> INTERNAL_RESET;
	endproperty
	property p_stretch;
		$fell(INTERNAL_RESET) |-> quiet >= TIMEOUT_CYCLES - TOUT_ONE;
	endproperty
	property p_release;
		quiet == TIMEOUT_CYCLES + 20'h0_0006 |-> !INTERNAL_RESET;
	endproperty
	property p_fetch;
		FETCH_AT_VECTOR |-> s_fetch_end;
	endproperty
	a_arm: assert property (p_arm) else $error("sleep entry without pulse");
	a_bod_off: assert property (p_bod_off) else $error("bod off not at entry");
	a_t2: assert property (p_t2) else $error("async timer 2 gated");
	a_adc: assert property (p_adc) else $error("adc gate flags wrong");
	a_access: assert property (p_access) else $error("gated access open");
	a_port: assert property (p_port) else $error("port reset missing");
	a_por: assert property (p_por) else $error("power-on not immediate");
	a_jtag: assert property (p_jtag) else $error("jtag hold missing");
	a_stretch: assert property (p_stretch) else $error("stretch too short");
	a_release: assert property (p_release) else $error("reset not released");
	a_fetch: assert property (p_fetch) else $error("fetch pulse wrong");
endmodule : sgrc_top_asserts

bind sgrc_top sgrc_top_asserts #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) sgrc_top_asserts_inst (
	.MCLK(MCLK), .RST_N(RST_N), .RST_SRC(RST_SRC), .SLEEP_INSTR(SLEEP_INSTR),
	.TIMER2_ASYNC_SELECT(TIMER2_ASYNC_SELECT), .ADC_ENABLED(ADC_ENABLED),
	.SLEEP_ENTER(SLEEP_ENTER), .BOD_SLEEP_OFF(BOD_SLEEP_OFF), .GATE_CLK(GATE_CLK),
	.PERIPH_ACCESS_OK(PERIPH_ACCESS_OK), .ADC_GATE_ERR(ADC_GATE_ERR),
	.COMPARATOR_MUX_BLOCK(COMPARATOR_MUX_BLOCK), .PORT_RESET(PORT_RESET),
	.INTERNAL_RESET(INTERNAL_RESET), .FETCH_AT_VECTOR(FETCH_AT_VECTOR));

// *** testbench/tb.sv ***
/*
 * Bench: core model on the bus, reset sources and levels driven here.
 * Assumes a shortened stretch count of eight cycles.
 */
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_fail++; \
	$display("CHECK FAILED at %0t: got %0h want %0h", $time, a, b); end end
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import sgrc_pkg::*;
	localparam logic [TOUT_W-1:0] T = 20'h0_0008;
	logic          mclk = 1'b0, rst_n = 1'b0, t2a = 1'b0, adc_en = 1'b0;
	sgrc_rst_src_t src = '0;
	sgrc_wb_req_t  req;
	sgrc_wb_rsp_t  rsp;
	logic          sl, ent, bod_off, ir, pr, fav, aerr, cblk;
	logic [2:0]    mode;
	logic [7:0]    gate, aok;
	int            n_fail = 0, check_count = 0, cyc = 0, hits;
	always #2.5 mclk = ~mclk;
	sgrc_top #(.TIMEOUT_CYCLES(T)) sgrc_top_inst (.MCLK(mclk), .RST_N(rst_n), .WB_REQ(req),
		.WB_RSP(rsp), .SLEEP_INSTR(sl), .TIMER2_ASYNC_SELECT(t2a), .ADC_ENABLED(adc_en),
		.RST_SRC(src), .PERIPH_SEL(6'h00), .SLEEP_ENTER(ent), .SLEEP_MODE(mode),
		.BOD_SLEEP_OFF(bod_off), .GATE_CLK(gate), .PERIPH_ACCESS_OK(aok), .ADC_GATE_ERR(aerr),
		.COMPARATOR_MUX_BLOCK(cblk), .PORT_RESET(pr), .INTERNAL_RESET(ir), .FETCH_AT_VECTOR(fav));
	sgrc_core_model sgrc_core_model_inst (.wb_rsp(rsp), .mclk(mclk), .wb_req(req), .sleep_instr(sl));
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [31:0] x;
		sgrc_core_model_inst.bus(1'b1, idx, {24'h00_0000, d}, x);
	endtask : wr
	task automatic rchk(input logic [7:0] idx, input logic [7:0] e);
		logic [31:0] x;
		sgrc_core_model_inst.bus(1'b0, idx, 32'h0000_0000, x);
		`CHK(x, {24'h00_0000, e})
	endtask : rchk
	task automatic rel_chk(input int lo);
		int n = 0;
		while (ir !== 1'b0 && n < 100) begin
			@(posedge mclk);
			#1 n++;
		end
		`CHK(n >= lo && n <= lo + 8, 1'b1)
		`CHK(fav, 1'b1)
	endtask : rel_chk
	task automatic t_regs();
		rchk(IDX_SLEEP_MODE_CONTROL, 8'h00);
		rchk(IDX_CORE_CONTROL, 8'h00);
		rchk(IDX_PERIPH_CLOCK_GATE, 8'h00);
		wr(IDX_SLEEP_MODE_CONTROL, 8'hFE);
		rchk(IDX_SLEEP_MODE_CONTROL, 8'h0E);
		wr(IDX_CORE_CONTROL, 8'h9F);
		rchk(IDX_CORE_CONTROL, 8'h93);
		wr(8'h10, 8'hAA);
		rchk(8'h10, 8'h00);
		@(posedge mclk);
		rst_n <= 1'b0;
		#1 `CHK(pr & ir, 1'b1)
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		#1 rel_chk(int'(T) - 1);
		rchk(IDX_SLEEP_MODE_CONTROL, 8'h00);
		rchk(IDX_CORE_CONTROL, 8'h00);
		$display("test regs done");
	endtask : t_regs
	task automatic t_sleep();
		logic [2:0] m [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
		// standby codes run as if the clock were a crystal
		foreach (m[i]) begin
			wr(IDX_SLEEP_MODE_CONTROL, {4'h0, m[i], 1'b1}); // arm just before sleep
			sgrc_core_model_inst.pulse_sleep();
			#1 `CHK({ent, mode}, {1'b1, m[i]})
			wr(IDX_SLEEP_MODE_CONTROL, 8'h00);
		end
		sgrc_core_model_inst.pulse_sleep();
		#1 `CHK(ent, 1'b0)
		$display("test sleep done");
	endtask : t_sleep
	task automatic t_bod();
		hits = 0;
		wr(IDX_SLEEP_MODE_CONTROL, 8'h05);
		for (int d = 0; d < 6; d++) begin
			wr(IDX_CORE_CONTROL, 8'h60);
			wr(IDX_CORE_CONTROL, 8'h40);
			repeat (d) @(posedge mclk);
			sgrc_core_model_inst.pulse_sleep();
			#1 hits += int'(bod_off === 1'b1);
		end
		`CHK(hits, 1)
		wr(IDX_CORE_CONTROL, 8'h60);
		wr(IDX_CORE_CONTROL, 8'h40);
		rchk(IDX_CORE_CONTROL, 8'h40);
		rchk(IDX_CORE_CONTROL, 8'h00);
		wr(IDX_CORE_CONTROL, 8'h60);
		repeat (6) @(posedge mclk);
		wr(IDX_CORE_CONTROL, 8'h40);
		sgrc_core_model_inst.pulse_sleep();
		#1 `CHK(bod_off, 1'b0)
		wr(IDX_SLEEP_MODE_CONTROL, 8'h00);
		$display("test bod done");
	endtask : t_bod
	task automatic t_gate();
		for (int i = 0; i < 8; i++) begin
			wr(IDX_PERIPH_CLOCK_GATE, 8'h01 << i);
			#1 `CHK({gate, aok}, {8'h01 << i, ~(8'h01 << i)})
			rchk(IDX_PERIPH_CLOCK_GATE, 8'h01 << i);
		end
		wr(IDX_PERIPH_CLOCK_GATE, 8'h40);
		@(posedge mclk);
		t2a <= 1'b1;
		#1 `CHK(gate, 8'h00)
		@(posedge mclk);
		t2a <= 1'b0;
		adc_en <= 1'b1;
		#1 `CHK(gate, 8'h40)
		wr(IDX_PERIPH_CLOCK_GATE, 8'h01);
		#1 `CHK({aerr, cblk}, 2'h3)
		@(posedge mclk);
		adc_en <= 1'b0;
		#1 `CHK({aerr, cblk}, 2'h1)
		wr(IDX_PERIPH_CLOCK_GATE, 8'h00); // software reinitialises after this
		#1 `CHK({gate, cblk}, 9'h000)
		$display("test gate done");
	endtask : t_gate
	task automatic t_rst();
		logic [6:0] pat [5] = '{7'h40, 7'h20, 7'h18, 7'h06, 7'h01};
		for (int k = 0; k < 5; k++) begin
			@(posedge mclk);
			src <= pat[k];
			#1 if (k != 2) `CHK({pr, ir}, 2'h3)
			@(posedge mclk);
			if (k == 2) src <= '0;
			#1 `CHK(ir, 1'b1)
			repeat (2) @(posedge mclk);
			src <= '0;
			#1 rel_chk(int'(T) - 3);
		end
		@(posedge mclk);
		src <= 7'h10;
		#1 `CHK(ir, 1'b0)
		@(posedge mclk);
		src <= 7'h04;
		#1 `CHK({pr, ir}, 2'h0)
		@(posedge mclk);
		src <= 7'h20;
		repeat (2) @(posedge mclk);
		src <= '0;
		repeat (4) @(posedge mclk);
		src <= 7'h20;
		repeat (2) @(posedge mclk);
		src <= '0;
		#1 rel_chk(int'(T) - 1);
		rchk(IDX_RESET_STATUS, 8'h1F);
		wr(IDX_RESET_STATUS, 8'h1F);
		rchk(IDX_RESET_STATUS, 8'h00);
		$display("test reset done");
	endtask : t_rst
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : print_verdict
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			print_verdict();
		end
	end
	initial begin
		repeat (20) @(posedge mclk);
		rst_n <= 1'b1;
		#1 rel_chk(int'(T) - 1);
		t_regs();
		t_sleep();
		t_bod();
		t_gate();
		t_rst();
		print_verdict();
	end
endmodule : tb
